// ### verilog/pwdt_top.sv
// prescaled watchdog timer with apb register access
`timescale 1ns/1ps
`include "pwdt_map.svh"
// What this block does
// - prescaler feeding 14-bit timer, overflow times out
// - counts only while run enable set
// - enabled time-out asserts wd_system_reset for 16 cycles, watchdog registers kept
// - chip reset leaves the watchdog disabled
// - chip reset clears timer and prescaler
// - restart bit clears timer, prescaler, itself
// - idle mode halts unless idle run set
// - select bits pick divide 2 to 256
// - interval is 2^14 times prescale times 12
// - idle stops the watchdog too unless idle run set
// - power-down freezes chain while cpu_power_down is high
module pwdt_top #(
   parameter int unsigned PS_BITS = 8,
   parameter int unsigned TIMER_BITS = `PWDT_TIMER_BITS
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // power state of the processor
   input wire logic cpu_idle,
   input wire logic cpu_power_down,
   // outputs
   output logic wd_timeout_pulse,
   output logic wd_system_reset,
   output logic irq
);
   ////////////////////////////////////////////////////////////////////////////
   logic [7:0] ctrl_q;
   logic [3:0] osc_q;
   logic [PS_BITS-1:0] ps_q;
   logic [TIMER_BITS-1:0] tmr_q;
   logic stat_q, mask_q, restart_q;
   logic [7:0] hold_q;
   pwdt_pkg::pwdt_state_t st_q;
   logic [2:0] sel;
   logic [3:0] ps_stage;
   logic wr, rd, run, osc_tick, ps_tick, ovf;
   logic hit_ctrl, hit_stat, hit_mask, hit_count;
   logic wd_run_enable, wd_restart_request, wd_idle_run;
   logic wd_prescale_sel_bit2, wd_prescale_sel_bit1, wd_prescale_sel_bit0;
   logic [PS_BITS-1:0] ps_mask;
   logic [31:0] rd_mux;

   ////////////////////////////////////////////////////////////////////////////
   // bus qualifiers; every access completes in its first access cycle
   assign wr = psel && penable && pwrite;
   assign rd = psel && !penable && !pwrite;
   assign pready = 1'b1;
   assign pslverr = 1'b0;

   // register address decode
   assign hit_ctrl = (paddr == `PWDT_CTRL_OFF);
   assign hit_stat = (paddr == `PWDT_STAT_OFF);
   assign hit_mask = (paddr == `PWDT_MASK_OFF);
   assign hit_count = (paddr == `PWDT_COUNT_OFF);

   // control fields by name
   assign wd_run_enable = ctrl_q[`PWDT_EN_BIT];
   assign wd_restart_request = restart_q;
   assign wd_idle_run = ctrl_q[`PWDT_IDLE_BIT];
   assign wd_prescale_sel_bit2 = ctrl_q[`PWDT_PS_LSB + 2];
   assign wd_prescale_sel_bit1 = ctrl_q[`PWDT_PS_LSB + 1];
   assign wd_prescale_sel_bit0 = ctrl_q[`PWDT_PS_LSB];
   assign sel = {wd_prescale_sel_bit2, wd_prescale_sel_bit1, wd_prescale_sel_bit0};

   // enable, idle gating and power-down freeze
   assign run = wd_run_enable && !cpu_power_down &&
                (!cpu_idle || wd_idle_run);

   ////////////////////////////////////////////////////////////////////////////
   // select code to ratio exponent minus one (000:2, 010:4, 001:8, 011:16)
   always_comb begin
      case (sel)
         3'h0: ps_stage = 4'h0;
         3'h2: ps_stage = 4'h1;
         3'h1: ps_stage = 4'h2;
         3'h3: ps_stage = 4'h3;
         3'h4: ps_stage = 4'h4;
         3'h5: ps_stage = 4'h5;
         3'h6: ps_stage = 4'h6;
         default: ps_stage = 4'h7;
      endcase
   end

   // prescaler bits that must all be one at the last count of a ratio
   always_comb begin
      ps_mask = '0;
      for (int i = 0; i < PS_BITS; i++) begin
         if (i <= int'(ps_stage)) begin
            ps_mask[i] = 1'b1;
         end
      end
   end

   // twelve oscillator periods form one count of the prescaler
   // no tick in the restart cycle, so a restart never races a time-out
   assign osc_tick = run && !restart_q && (osc_q == 4'(`PWDT_OSC_PER_CYC - 1));
   assign ps_tick = osc_tick && ((ps_q & ps_mask) == ps_mask);
   assign ovf = ps_tick && (&tmr_q);

   ////////////////////////////////////////////////////////////////////////////
   // oscillator divider, prescaler and timer share one counter shape
   pwdt_count #(
      .WIDTH(4)
   ) i_osc (
      .clk(pclk),
      .rst_n(presetn),
      .clr(restart_q || osc_tick),
      .inc(run),
      .cnt_q(osc_q)
   );

   pwdt_count #(
      .WIDTH(PS_BITS)
   ) i_ps (
      .clk(pclk),
      .rst_n(presetn),
      .clr(restart_q),
      .inc(osc_tick),
      .cnt_q(ps_q)
   );

   pwdt_count #(
      .WIDTH(TIMER_BITS)
   ) i_tmr (
      .clk(pclk),
      .rst_n(presetn),
      .clr(restart_q),
      .inc(ps_tick),
      .cnt_q(tmr_q)
   );

   ////////////////////////////////////////////////////////////////////////////
   // control register; the restart bit is never stored, so it reads zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= `PWDT_CTRL_RESET;
      end else if (wr && hit_ctrl) begin
         ctrl_q <= pwdata[7:0] & 8'h97;
      end
   end

   // restart request lives one cycle, then clears itself
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         restart_q <= 1'b0;
      end else begin
         restart_q <= wr && hit_ctrl && pwdata[`PWDT_RESTART_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sticky time-out status, write one to clear, set wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_q <= 1'b0;
      end else if (ovf) begin
         stat_q <= 1'b1;
      end else if (wr && hit_stat && pwdata[0]) begin
         stat_q <= 1'b0;
      end
   end

   // interrupt mask of the same layout
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_q <= 1'b0;
      end else if (wr && hit_mask) begin
         mask_q <= pwdata[0];
      end
   end

   assign irq = stat_q && mask_q;

   ////////////////////////////////////////////////////////////////////////////
   // time-out pulse for one cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wd_timeout_pulse <= 1'b0;
      end else begin
         wd_timeout_pulse <= ovf;
      end
   end

   // reset sequencer state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= pwdt_pkg::PWDT_IDLE_S;
      end else begin
         case (st_q)
            pwdt_pkg::PWDT_IDLE_S: begin
               if (ovf) begin
                  st_q <= pwdt_pkg::PWDT_HOLD_S;
               end else if (wd_run_enable) begin
                  st_q <= pwdt_pkg::PWDT_RUN_S;
               end
            end
            pwdt_pkg::PWDT_RUN_S: begin
               if (ovf) begin
                  st_q <= pwdt_pkg::PWDT_HOLD_S;
               end else if (!wd_run_enable) begin
                  st_q <= pwdt_pkg::PWDT_IDLE_S;
               end
            end
            pwdt_pkg::PWDT_HOLD_S: begin
               if (hold_q == 8'h01) begin
                  st_q <= pwdt_pkg::PWDT_IDLE_S;
               end
            end
            default: begin
               st_q <= pwdt_pkg::PWDT_IDLE_S;
            end
         endcase
      end
   end

   // length of the generated reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_q <= 8'h00;
      end else if (ovf && st_q != pwdt_pkg::PWDT_HOLD_S) begin
         hold_q <= `PWDT_RST_HOLD;
      end else if (st_q == pwdt_pkg::PWDT_HOLD_S) begin
         hold_q <= hold_q - 8'h01;
      end
   end

   // generated reset stands for the whole hold
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wd_system_reset <= 1'b0;
      end else if (ovf && st_q != pwdt_pkg::PWDT_HOLD_S) begin
         wd_system_reset <= 1'b1;
      end else if (st_q == pwdt_pkg::PWDT_HOLD_S && hold_q == 8'h01) begin
         wd_system_reset <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read data of the addressed register, zero when unmapped
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_ctrl) begin
         rd_mux = {24'h000000, ctrl_q};
      end else if (hit_stat) begin
         rd_mux = {31'h0, stat_q};
      end else if (hit_mask) begin
         rd_mux = {31'h0, mask_q};
      end else if (hit_count) begin
         rd_mux = 32'(tmr_q);
      end
   end

   // read data is captured in the setup cycle and stands through access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd) begin
         prdata <= rd_mux;
      end
   end

endmodule : pwdt_top

////////////////////////////////////////////////////////////////////////////////
// clearable up-counter; clear wins over count
module pwdt_count #(
   parameter int unsigned WIDTH = 4
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control
   input wire logic clr,
   input wire logic inc,
   // count
   output logic [WIDTH-1:0] cnt_q
);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
      end else if (clr) begin
         cnt_q <= '0;
      end else if (inc) begin
         cnt_q <= cnt_q + WIDTH'(1);
      end
   end
endmodule : pwdt_count

// ### verilog/pwdt_map.svh
// register offsets, field positions and timing counts of the watchdog
`ifndef PWDT_MAP_SVH
`define PWDT_MAP_SVH
`define PWDT_CTRL_OFF 12'h000
`define PWDT_STAT_OFF 12'h004
`define PWDT_MASK_OFF 12'h008
`define PWDT_COUNT_OFF 12'h00c
`define PWDT_PS_LSB 0
`define PWDT_IDLE_BIT 4
`define PWDT_RESTART_BIT 6
`define PWDT_EN_BIT 7
`define PWDT_CTRL_RESET 8'h00
`define PWDT_OSC_PER_CYC 12
`define PWDT_TIMER_BITS 14
`define PWDT_RST_HOLD 8'h10
`endif

// ### verilog/pwdt_pkg.sv
// types of the watchdog
package pwdt_pkg;
   typedef enum logic [1:0] {PWDT_IDLE_S, PWDT_RUN_S, PWDT_HOLD_S} pwdt_state_t;
endpackage : pwdt_pkg

// ### test/pwdt_top_asserts.sv
// port assertions of the watchdog
`timescale 1ns/1ps
module pwdt_top_asserts (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // bus and power state
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic cpu_power_down,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // outputs
   input wire logic wd_timeout_pulse,
   input wire logic wd_system_reset
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_hold; wd_system_reset [*8]; endsequence
   property p_one; wd_timeout_pulse |=> !wd_timeout_pulse; endproperty
   property p_rst; wd_timeout_pulse |-> wd_system_reset; endproperty
   property p_cause; $rose(wd_system_reset) |-> wd_timeout_pulse; endproperty
   property p_hold; $rose(wd_system_reset) |-> s_hold ##1 s_hold ##1 !wd_system_reset; endproperty
   property p_rdy; psel && penable |-> pready; endproperty
   property p_err; !pslverr; endproperty
   property p_rdh; !(psel && !penable && !pwrite) |=> $stable(prdata); endproperty
   property p_pd; cpu_power_down && $past(cpu_power_down) |-> !wd_timeout_pulse; endproperty
   a_one: assert property (p_one) else $error("pulse too long");
   a_rst: assert property (p_rst) else $error("pulse without reset");
   a_cause: assert property (p_cause) else $error("reset without pulse");
   a_hold: assert property (p_hold) else $error("reset hold wrong");
   a_rdy: assert property (p_rdy) else $error("no ready");
   a_err: assert property (p_err) else $error("slave error");
   a_rdh: assert property (p_rdh) else $error("read data moved");
   a_pd: assert property (p_pd) else $error("pulse in power down");
endmodule : pwdt_top_asserts
bind pwdt_top pwdt_top_asserts i_chk (.pclk, .presetn, .psel, .penable, .pwrite,
   .cpu_power_down, .prdata, .pready, .pslverr, .wd_timeout_pulse, .wd_system_reset);

// ### test/prescaled_watchdog_timer_test.sv
// self-checking bench of the watchdog
`timescale 1ns/1ps
`include "pwdt_map.svh"
module prescaled_watchdog_timer_test;
   localparam int TB = 4;
   localparam logic [2:0] SEL [3] = '{3'h0, 3'h2, 3'h1};
   logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic cpu_idle = 1'h0, cpu_power_down = 1'h0, pready, pslverr, wd_timeout_pulse;
   logic wd_system_reset, irq;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, v, w;
   int n_errors = 0, n_checks = 0, t, e;
   always #2 pclk = ~pclk;
   pwdt_top #(.TIMER_BITS(TB)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .cpu_idle, .cpu_power_down, .wd_timeout_pulse,
      .wd_system_reset, .irq);
   ////////////////////////////////////////////////////////////////////////////////
   task automatic conclude;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : conclude
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      for (i = 0; i < 50; i++) begin
         @(posedge pclk);
         if (pready === 1'h1) break;
      end
      v = prdata;
      psel <= 1'h0;
      penable <= 1'h0;
      if (i == 50) n_errors++;
      if (i == 50) conclude();
   endtask : apb
   task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
      apb(1'h0, a, 32'h0);
      chk(nm, v, exp);
   endtask : rd
   task automatic wait_to(input int lim);
      for (t = 0; t < lim && wd_timeout_pulse !== 1'h1; t++) @(negedge pclk);
   endtask : wait_to
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #100000;
      n_errors++;
      conclude();
   end
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'h1;
      rd("ctrl", `PWDT_CTRL_OFF, 32'h0);
      rd("count", `PWDT_COUNT_OFF, 32'h0);
      rd("unmapped", 12'h010, 32'h0);
      repeat (400) @(posedge pclk);
      rd("count off", `PWDT_COUNT_OFF, 32'h0);
      apb(1'h1, `PWDT_MASK_OFF, 32'h1);
      for (int k = 0; k < 3; k++) begin
         e = (1 << TB) * (2 << k) * `PWDT_OSC_PER_CYC;
         apb(1'h1, `PWDT_CTRL_OFF, 32'hc0 | SEL[k]);
         wait_to(e + 50);
         chk("interval", t >= e - 3 && t <= e + 3, 32'h1);
         chk("sysrst", wd_system_reset, 32'h1);
         rd("ctrl", `PWDT_CTRL_OFF, 32'h80 | SEL[k]);
         chk("irq", irq, 32'h1);
         apb(1'h1, `PWDT_STAT_OFF, 32'h1);
         rd("stat", `PWDT_STAT_OFF, 32'h0);
      end
      apb(1'h1, `PWDT_CTRL_OFF, 32'hc0);
      repeat (300) @(posedge pclk);
      apb(1'h1, `PWDT_CTRL_OFF, 32'hc0);
      wait_to(300);
      chk("restart", t, 32'd300);
      @(posedge pclk);
      cpu_idle <= 1'h1;
      apb(1'h0, `PWDT_COUNT_OFF, 32'h0);
      w = v;
      repeat (100) @(posedge pclk);
      rd("idle halt", `PWDT_COUNT_OFF, w);
      apb(1'h1, `PWDT_CTRL_OFF, 32'h90);
      repeat (100) @(posedge pclk);
      apb(1'h0, `PWDT_COUNT_OFF, 32'h0);
      chk("idle run", v !== w, 32'h1);
      cpu_idle <= 1'h0;
      cpu_power_down <= 1'h1;
      apb(1'h0, `PWDT_COUNT_OFF, 32'h0);
      w = v;
      repeat (100) @(posedge pclk);
      rd("frozen", `PWDT_COUNT_OFF, w);
      conclude();
   end
endmodule : prescaled_watchdog_timer_test
